// ### bench/mbrr_regs_assertions.sv
// Port checker for the moisture burst result register bank
`timescale 1ns/1ns
module mbrr_regs_assertions #(
   parameter int unsigned ADDR_W = 8,
   parameter int unsigned DATA_W = 8
) (
   // Clock and reset
   input logic                   ref_clk_i,
   input logic                   rst_i,
   // Engine side
   input logic                   cc2_load_i,
   input mbrr_pkg::mbrr_result_t cc2_result_i,
   input logic                   sbu1_load_i,
   input mbrr_pkg::mbrr_result_t sbu1_result_i,
   input logic                   sbu2_load_i,
   input mbrr_pkg::mbrr_result_t sbu2_result_i,
   // Register port
   input logic [ADDR_W-1:0]      reg_addr_i,
   input logic                   reg_rd_i,
   input logic                   reg_wr_i,
   input logic [DATA_W-1:0]      reg_wdata_i,
   input logic [DATA_W-1:0]      reg_rdata_o,
   input logic                   reg_rvalid_o,
   input logic                   reg_wack_o,
   input logic [2:0]             result_loaded_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   // Set by any load; until then every read must show the reset value
   logic seen_load_r;
   always_ff @(posedge ref_clk_i) begin
      if (rst_i)
         seen_load_r <= 1'b0;
      else if (cc2_load_i | sbu1_load_i | sbu2_load_i)
         seen_load_r <= 1'b1;
   end
   // Read issued in the cycle right after a load
   sequence rd_s(ofs);
      reg_rd_i && reg_addr_i == ofs;
   endsequence
   cc2_abort_adc_a: assert property (cc2_load_i && cc2_result_i.outcome == mbrr_pkg::MBRR_ABORT
      ##1 rd_s(8'h57) |=> reg_rdata_o == 8'h00) else $error("cc2 abort adc");
   sbu1_open_adc_a: assert property (sbu1_load_i && sbu1_result_i.outcome == mbrr_pkg::MBRR_OPEN
      ##1 rd_s(8'h59) |=> reg_rdata_o == 8'hff) else $error("sbu1 open adc");
   sbu2_gnd_adc_a: assert property (sbu2_load_i && sbu2_result_i.outcome == mbrr_pkg::MBRR_GROUND
      ##1 rd_s(8'h5b) |=> reg_rdata_o == 8'h00) else $error("sbu2 ground adc");
   sbu2_meas_adc_a: assert property (sbu2_load_i && sbu2_result_i.outcome == mbrr_pkg::MBRR_MEASURED
      ##1 rd_s(8'h5b) |=> reg_rdata_o == $past(sbu2_result_i.adc_value, 2))
      else $error("sbu2 measured adc");
   outcome_shape_a: assert property (reg_rvalid_o && ($past(reg_addr_i) inside {8'h56, 8'h58, 8'h5a})
      |-> reg_rdata_o[7:5] == 3'h0 && $onehot0(reg_rdata_o[4:2])
      && (!reg_rdata_o[4] || reg_rdata_o[1:0] == 2'h3)
      && (!(reg_rdata_o[3] || reg_rdata_o[2]) || reg_rdata_o[1:0] == 2'h0))
      else $error("outcome byte shape");
   write_ack_a: assert property (reg_wr_i && !reg_rd_i |=> reg_wack_o && !reg_rvalid_o)
      else $error("write answer");
   reset_read_a: assert property (reg_rvalid_o && !seen_load_r |-> reg_rdata_o == 8'h00)
      else $error("read before load");
   load_pulse_a: assert property (|{sbu2_load_i, sbu1_load_i, cc2_load_i}
      |=> result_loaded_o == $past({sbu2_load_i, sbu1_load_i, cc2_load_i}))
      else $error("loaded pulse");
endmodule

// ### bench/tb_moisture_burst_result_regs.sv
// Self-checking bench for the moisture burst result register bank
`timescale 1ns/1ns
module tb_moisture_burst_result_regs;
   logic ref_clk_i = 1'b0, rst_i = 1'b1, rd = 1'b0, wr = 1'b0, rvalid, wack;
   logic [2:0] ld = 3'h0, loaded;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   mbrr_pkg::mbrr_result_t res [3] = '{default: 12'h000};
   int n_errors = 0, checked = 0;
   always #4 ref_clk_i = ~ref_clk_i;
   mbrr_moisture_burst_result_regs i_mbrr_moisture_burst_result_regs (.ref_clk_i(ref_clk_i),
      .rst_i(rst_i), .cc2_load_i(ld[0]), .cc2_result_i(res[0]), .sbu1_load_i(ld[1]),
      .sbu1_result_i(res[1]), .sbu2_load_i(ld[2]), .sbu2_result_i(res[2]), .reg_addr_i(addr),
      .reg_rd_i(rd), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
      .reg_rvalid_o(rvalid), .reg_wack_o(wack), .result_loaded_o(loaded));
   task automatic test_done();
      if (n_errors == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Strobes move on falling edges only; a read leaves one idle edge so rd never toggles twice
   task automatic rdc(input logic [7:0] ofs, input logic [7:0] exp);
      addr = ofs;
      rd = 1'b1;
      @(negedge ref_clk_i);
      rd = 1'b0;
      chk("rvalid", {7'h0, rvalid}, 8'h01);
      chk("rdata", rdata, exp);
      @(negedge ref_clk_i);
      chk("rvalid drop", {7'h0, rvalid}, 8'h00);
      chk("rdata hold", rdata, exp);
   endtask
   task automatic load(input int p, input mbrr_pkg::mbrr_outcome_t o, input logic [1:0] c,
                       input logic [7:0] a);
      res[p] = '{o, c, a};
      ld[p] = 1'b1;
      @(negedge ref_clk_i);
      ld = 3'h0;
      chk("loaded", {5'h0, loaded}, 8'h01 << p);
   endtask
   // Reset value everywhere, holes included
   task automatic t_reset();
      for (int i = 0; i < 9; i++)
         rdc(8'h54 + 8'(i), 8'h00);
   endtask
   // Every outcome and every current code on every pin; forced code must override input
   task automatic t_outcomes();
      mbrr_pkg::mbrr_outcome_t o;
      logic [7:0] e;
      for (int p = 0; p < 3; p++) begin
         for (int k = 0; k < 7; k++) begin
            o = mbrr_pkg::mbrr_outcome_t'(k < 4 ? 2'h0 : 2'(k - 3));
            load(p, o, k < 4 ? 2'(k) : 2'h2, 8'h7e - 8'(k));
            e = (o == mbrr_pkg::MBRR_OPEN) ? 8'hff : (k < 4) ? 8'h7e - 8'(k) : 8'h00;
            rdc(8'h57 + 8'(2 * p), e);
            e = (k < 4) ? 8'(k) : (k == 4) ? 8'h13 : (k == 5) ? 8'h08 : 8'h04;
            rdc(8'h56 + 8'(2 * p), e);
         end
      end
   endtask
   // Writes are acknowledged and change nothing; last loads were Open
   task automatic t_write();
      for (int i = 0; i < 6; i++) begin
         addr = 8'h56 + 8'(i);
         wdata = 8'ha5;
         wr = 1'b1;
         @(negedge ref_clk_i);
         wr = 1'b0;
         chk("wack", {7'h0, wack}, 8'h01);
         rdc(8'h56 + 8'(i), i[0] ? 8'hff : 8'h04);
      end
   endtask
   // All pins load at once; a read in the load cycle still sees the old burst
   task automatic t_simul();
      logic [7:0] e [6] = '{8'h13, 8'h00, 8'h08, 8'h00, 8'h01, 8'h5a};
      res[0] = '{mbrr_pkg::MBRR_GROUND, 2'h1, 8'h33};
      res[1] = '{mbrr_pkg::MBRR_ABORT, 2'h3, 8'h44};
      res[2] = '{mbrr_pkg::MBRR_MEASURED, 2'h1, 8'h5a};
      // Loads and read share one edge: the read must still return the older Open burst
      ld = 3'h7;
      addr = 8'h59;
      rd = 1'b1;
      @(negedge ref_clk_i);
      ld = 3'h0;
      rd = 1'b0;
      chk("rvalid", {7'h0, rvalid}, 8'h01);
      chk("rdata", rdata, 8'hff);
      chk("loaded", {5'h0, loaded}, 8'h07);
      @(negedge ref_clk_i);
      for (int i = 0; i < 6; i++)
         rdc(8'h56 + 8'(i), e[i]);
      rst_i = 1'b1;
      repeat (2) @(negedge ref_clk_i);
      rst_i = 1'b0;
      rdc(8'h5a, 8'h00);
   endtask
   initial begin
      repeat (6) @(negedge ref_clk_i);
      rst_i = 1'b0;
      t_reset();
      t_outcomes();
      t_write();
      t_simul();
      test_done();
   end
   // Watchdog: the run needs well under 1000 cycles
   initial begin
      repeat (5000) @(posedge ref_clk_i);
      n_errors++;
      test_done();
   end
endmodule
bind mbrr_moisture_burst_result_regs mbrr_regs_assertions #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
   i_mbrr_regs_assertions (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .cc2_load_i(cc2_load_i),
   .cc2_result_i(cc2_result_i), .sbu1_load_i(sbu1_load_i), .sbu1_result_i(sbu1_result_i),
   .sbu2_load_i(sbu2_load_i), .sbu2_result_i(sbu2_result_i), .reg_addr_i(reg_addr_i),
   .reg_rd_i(reg_rd_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
   .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .reg_wack_o(reg_wack_o),
   .result_loaded_o(result_loaded_o));

// ### design/mbrr_pin_result.sv
// Result holder for one measured pin: forces codes and latches one burst
`timescale 1ns/1ns
module mbrr_pin_result (
   // Clock and reset
   input  logic                    ref_clk_i,
   input  logic                    rst_i,
   // Engine side
   input  logic                    load_i,
   input  mbrr_pkg::mbrr_result_t  result_i,
   // Stored result
   output mbrr_pkg::mbrr_pin_regs_t pin_regs_o
);

   mbrr_pkg::mbrr_pin_regs_t pin_r;    // Held result
   mbrr_pkg::mbrr_pin_regs_t pin_nxt;  // Next held result
   mbrr_pkg::mbrr_pin_regs_t conv;     // Result after forcing

   // ==========================================================================
   // Forcing of code and ADC value by outcome
   always_comb begin
      conv.ground_flag       = (result_i.outcome == mbrr_pkg::MBRR_GROUND);
      conv.abort_flag        = (result_i.outcome == mbrr_pkg::MBRR_ABORT);
      conv.open_flag         = (result_i.outcome == mbrr_pkg::MBRR_OPEN);
      conv.final_pullup_code = result_i.pullup_code;  // Measured: engine code
      conv.final_adc_value   = result_i.adc_value;    // Measured: averaged reading
      case (result_i.outcome)
         mbrr_pkg::MBRR_GROUND: begin
            conv.final_pullup_code = mbrr_pkg::MBRR_IPU_128UA;
            conv.final_adc_value   = mbrr_pkg::MBRR_ADC_LOW;
         end
         mbrr_pkg::MBRR_ABORT: begin
            conv.final_pullup_code = mbrr_pkg::MBRR_IPU_2UA;
            conv.final_adc_value   = mbrr_pkg::MBRR_ADC_LOW;
         end
         mbrr_pkg::MBRR_OPEN: begin
            conv.final_pullup_code = mbrr_pkg::MBRR_IPU_2UA;
            conv.final_adc_value   = mbrr_pkg::MBRR_ADC_HIGH;
         end
         default: begin
            // Reading kept as measured
         end
      endcase
   end

   // ==========================================================================
   // Whole result replaced at once so a read never mixes two bursts
   always_comb begin
      pin_nxt = pin_r;
      if (load_i) begin
         pin_nxt = conv;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         pin_r <= mbrr_pkg::MBRR_PIN_RESET;
      end else begin
         pin_r <= pin_nxt;
      end
   end

   assign pin_regs_o = pin_r;

endmodule

// ### design/mbrr_pkg.sv
// Constants and types shared by the moisture burst result register bank
package mbrr_pkg;

   // ==========================================================================
   // Register offsets
   localparam logic [7:0] MBRR_CC2_OUTCOME_OFS   = 8'h56;
   localparam logic [7:0] MBRR_CC2_ADC_OFS       = 8'h57;
   localparam logic [7:0] MBRR_SBU1_OUTCOME_OFS  = 8'h58;
   localparam logic [7:0] MBRR_SBU1_ADC_OFS      = 8'h59;
   localparam logic [7:0] MBRR_SBU2_OUTCOME_OFS  = 8'h5a;
   localparam logic [7:0] MBRR_SBU2_ADC_OFS      = 8'h5b;

   // ==========================================================================
   // Outcome register field positions
   localparam int unsigned MBRR_GROUND_BIT = 4;
   localparam int unsigned MBRR_ABORT_BIT  = 3;
   localparam int unsigned MBRR_OPEN_BIT   = 2;
   localparam int unsigned MBRR_CODE_LSB   = 0;     // Code sits in bits 1:0

   // ==========================================================================
   // Reset and forced values
   localparam logic [7:0] MBRR_REG_RESET   = 8'h00;
   localparam logic [7:0] MBRR_UNMAPPED    = 8'h00; // Read of a hole answers zero
   localparam logic [7:0] MBRR_ADC_LOW     = 8'h00;
   localparam logic [7:0] MBRR_ADC_HIGH    = 8'hff;

   // ==========================================================================
   // Pullup current codes
   localparam logic [1:0] MBRR_IPU_2UA     = 2'h0;
   localparam logic [1:0] MBRR_IPU_8UA     = 2'h1;
   localparam logic [1:0] MBRR_IPU_32UA    = 2'h2;
   localparam logic [1:0] MBRR_IPU_128UA   = 2'h3;

   // ==========================================================================
   // ADC scale, one code step
   localparam int unsigned MBRR_ADC_LSB_UV      = 5882;  // Microvolts per step
   localparam int unsigned MBRR_ADC_LSB_PPM_FS  = 3920;  // 0.392% of full scale

   // ==========================================================================
   // Pin numbering inside the bank
   localparam int unsigned MBRR_PIN_CC2  = 0;
   localparam int unsigned MBRR_PIN_SBU1 = 1;
   localparam int unsigned MBRR_PIN_SBU2 = 2;
   localparam int unsigned MBRR_NUM_PINS = 3;

   // Burst conclusion reported by the measurement engine
   typedef enum logic [1:0] {
      MBRR_MEASURED = 2'b00,                         // Resistive reading kept
      MBRR_GROUND   = 2'b01,
      MBRR_ABORT    = 2'b10,
      MBRR_OPEN     = 2'b11
   } mbrr_outcome_t;

   // Raw result handed over with a load strobe
   typedef struct packed {
      mbrr_outcome_t outcome;
      logic [1:0]    pullup_code;
      logic [7:0]    adc_value;
   } mbrr_result_t;

   // Stored result of one pin
   typedef struct packed {
      logic       ground_flag;
      logic       abort_flag;
      logic       open_flag;
      logic [1:0] final_pullup_code;
      logic [7:0] final_adc_value;
   } mbrr_pin_regs_t;

   localparam mbrr_pin_regs_t MBRR_PIN_RESET = '{1'b0, 1'b0, 1'b0, 2'h0, 8'h00};

endpackage

// ### design/moisture_burst_result_regs.sv
// Read-only moisture burst result register bank for CC2, SBU1 and SBU2
`timescale 1ns/1ns
module mbrr_moisture_burst_result_regs #(
   parameter int unsigned ADDR_W = 8,                  // Register address width
   parameter int unsigned DATA_W = 8                   // Register data width
) (
   // Clock and reset
   input  logic                   ref_clk_i,
   input  logic                   rst_i,
   // Measurement engine: one load strobe per pin
   input  logic                   cc2_load_i,
   input  mbrr_pkg::mbrr_result_t cc2_result_i,
   input  logic                   sbu1_load_i,
   input  mbrr_pkg::mbrr_result_t sbu1_result_i,
   input  logic                   sbu2_load_i,
   input  mbrr_pkg::mbrr_result_t sbu2_result_i,
   // Register access port
   input  logic [ADDR_W-1:0]      reg_addr_i,
   input  logic                   reg_rd_i,
   input  logic                   reg_wr_i,
   input  logic [DATA_W-1:0]      reg_wdata_i,
   output logic [DATA_W-1:0]      reg_rdata_o,
   output logic                   reg_rvalid_o,
   output logic                   reg_wack_o,
   // Per-pin fresh-result pulses
   output logic [2:0]             result_loaded_o
);

   // ==========================================================================
   // Gathered engine inputs
   logic [2:0]                    load_vec;     // Load strobe per pin
   mbrr_pkg::mbrr_result_t        res_vec [3];  // Raw result per pin
   mbrr_pkg::mbrr_pin_regs_t      pin_regs [3]; // Stored result per pin

   always_comb begin
      load_vec[mbrr_pkg::MBRR_PIN_CC2]  = cc2_load_i;
      load_vec[mbrr_pkg::MBRR_PIN_SBU1] = sbu1_load_i;
      load_vec[mbrr_pkg::MBRR_PIN_SBU2] = sbu2_load_i;
      res_vec[mbrr_pkg::MBRR_PIN_CC2]   = cc2_result_i;
      res_vec[mbrr_pkg::MBRR_PIN_SBU1]  = sbu1_result_i;
      res_vec[mbrr_pkg::MBRR_PIN_SBU2]  = sbu2_result_i;
   end

   // ==========================================================================
   // One result holder per pin
   genvar gi;
   generate
      for (gi = 0; gi < mbrr_pkg::MBRR_NUM_PINS; gi++) begin : g_pin
         mbrr_pin_result u_pin (
            .ref_clk_i  (ref_clk_i),
            .rst_i      (rst_i),
            .load_i     (load_vec[gi]),
            .result_i   (res_vec[gi]),
            .pin_regs_o (pin_regs[gi])
         );
      end
   endgenerate

   // ==========================================================================
   // Outcome byte: flags in 4:2, pullup code in 1:0, upper bits zero
   function automatic logic [7:0] outcome_byte(input mbrr_pkg::mbrr_pin_regs_t p);
      logic [7:0] b;
      b = mbrr_pkg::MBRR_REG_RESET;
      b[mbrr_pkg::MBRR_GROUND_BIT]        = p.ground_flag;
      b[mbrr_pkg::MBRR_ABORT_BIT]         = p.abort_flag;
      b[mbrr_pkg::MBRR_OPEN_BIT]          = p.open_flag;
      b[mbrr_pkg::MBRR_CODE_LSB +: 2]     = p.final_pullup_code;
      return b;
   endfunction

   // ==========================================================================
   // Read decode; writes are acknowledged but never change a result
   logic [7:0]        rd_byte;      // Decoded read value
   logic [DATA_W-1:0] rdata_r;      // Registered read data
   logic [DATA_W-1:0] rdata_nxt;
   logic              rvalid_r;     // Read answer pulse
   logic              rvalid_nxt;
   logic              wack_r;       // Write answer pulse
   logic              wack_nxt;
   logic [2:0]        loaded_r;     // Fresh-result pulses
   logic [2:0]        loaded_nxt;

   always_comb begin
      if (reg_addr_i == ADDR_W'(mbrr_pkg::MBRR_CC2_OUTCOME_OFS)) begin
         rd_byte = outcome_byte(pin_regs[mbrr_pkg::MBRR_PIN_CC2]);
      end else if (reg_addr_i == ADDR_W'(mbrr_pkg::MBRR_CC2_ADC_OFS)) begin
         rd_byte = pin_regs[mbrr_pkg::MBRR_PIN_CC2].final_adc_value;
      end else if (reg_addr_i == ADDR_W'(mbrr_pkg::MBRR_SBU1_OUTCOME_OFS)) begin
         rd_byte = outcome_byte(pin_regs[mbrr_pkg::MBRR_PIN_SBU1]);
      end else if (reg_addr_i == ADDR_W'(mbrr_pkg::MBRR_SBU1_ADC_OFS)) begin
         rd_byte = pin_regs[mbrr_pkg::MBRR_PIN_SBU1].final_adc_value;
      end else if (reg_addr_i == ADDR_W'(mbrr_pkg::MBRR_SBU2_OUTCOME_OFS)) begin
         rd_byte = outcome_byte(pin_regs[mbrr_pkg::MBRR_PIN_SBU2]);
      end else if (reg_addr_i == ADDR_W'(mbrr_pkg::MBRR_SBU2_ADC_OFS)) begin
         rd_byte = pin_regs[mbrr_pkg::MBRR_PIN_SBU2].final_adc_value;
      end else begin
         rd_byte = mbrr_pkg::MBRR_UNMAPPED;   // Holes read as zero
      end
   end

   // Next values of the answer flops
   always_comb begin
      rdata_nxt  = rdata_r;                   // Data held until the next read
      rvalid_nxt = reg_rd_i;
      wack_nxt   = reg_wr_i;                  // Write data dropped on purpose
      loaded_nxt = load_vec;
      if (reg_rd_i) begin
         rdata_nxt = DATA_W'(rd_byte);
      end
   end

   // Answer flops; all outputs leave from here
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         rdata_r  <= DATA_W'(mbrr_pkg::MBRR_REG_RESET);
         rvalid_r <= 1'b0;
         wack_r   <= 1'b0;
         loaded_r <= 3'h0;
      end else begin
         rdata_r  <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
         wack_r   <= wack_nxt;
         loaded_r <= loaded_nxt;
      end
   end

   assign reg_rdata_o     = rdata_r;
   assign reg_rvalid_o    = rvalid_r;
   assign reg_wack_o      = wack_r;
   assign result_loaded_o = loaded_r;

   // reg_wdata_i is accepted for port completeness only; every register is read-only
   logic unused_wdata;
   assign unused_wdata = ^reg_wdata_i;

endmodule
